// file: design/ldoec_dev.sv
// Segment driver end: serial command receiver and display-off frame sequencer
`timescale 1ns/10ps
module ldoec_dev
    import ldoec_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst_n,
    ldoec_link_if.dev   link,
    input  wire logic [49:0] seg_data,
    output logic [49:0] seg,
    output logic [3:0]  com,
    output logic        parked,
    output logic        shutting_down,
    output logic        ext_mode
);

    // ============================================================
    // Pin synchronisers and filtered levels
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] ext_s;
    logic       scl_f;
    logic       sda_f;
    logic       ext_f;
    logic       next_scl_f;
    logic       next_sda_f;
    logic       next_ext_f;

    // A level counts only once the second and third stages agree
    always_comb begin
        next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
        next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
        next_ext_f = (ext_s[1] == ext_s[2]) ? ext_s[2] : ext_f;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            ext_s <= 3'h0;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            ext_f <= 1'b0;
        end else begin
            scl_s <= {scl_s[1:0], link.scl};
            sda_s <= {sda_s[1:0], link.sda};
            ext_s <= {ext_s[1:0], link.ext_clk};
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            ext_f <= next_ext_f;
        end
    end

    // ============================================================
    // Serial receiver
    logic       in_frame;
    logic       first_byte;
    logic       addressed;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic       ack_drive;
    logic       next_in_frame;
    logic       next_first_byte;
    logic       next_addressed;
    logic [3:0] next_bitcnt;
    logic [7:0] next_shreg;
    logic       next_ack_drive;
    logic       cmd_valid;
    logic [7:0] cmd_byte;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;

    // Edges come from the filtered levels, never from a first stage
    always_comb begin
        scl_rise        = next_scl_f & ~scl_f;
        scl_fall        = ~next_scl_f & scl_f;
        start_ev        = scl_f & next_scl_f & sda_f & ~next_sda_f;
        stop_ev         = scl_f & next_scl_f & ~sda_f & next_sda_f;
        next_in_frame   = in_frame;
        next_first_byte = first_byte;
        next_addressed  = addressed;
        next_bitcnt     = bitcnt;
        next_shreg      = shreg;
        next_ack_drive  = ack_drive;
        cmd_valid       = 1'b0;
        cmd_byte        = shreg;
        if (start_ev) begin
            next_in_frame   = 1'b1;
            next_first_byte = 1'b1;
            next_addressed  = 1'b0;
            next_bitcnt     = 4'h0;
            next_ack_drive  = 1'b0;
        end else if (stop_ev) begin
            next_in_frame  = 1'b0;
            next_ack_drive = 1'b0;
        end else if (in_frame && scl_rise && bitcnt < 4'h8) begin
            next_shreg  = {shreg[6:0], sda_f};
            next_bitcnt = bitcnt + 4'h1;
        end else if (in_frame && scl_fall && bitcnt == 4'h8) begin
            // Byte complete: answer it in the acknowledge slot
            next_bitcnt     = 4'h9;
            next_first_byte = 1'b0;
            if (first_byte) begin
                next_addressed = (shreg == `LDOEC_SLAVE_ADDR);
                next_ack_drive = (shreg == `LDOEC_SLAVE_ADDR);
            end else if (addressed) begin
                next_ack_drive = 1'b1;
                cmd_valid      = 1'b1;
            end
        end else if (in_frame && scl_fall && bitcnt == 4'h9) begin
            next_bitcnt    = 4'h0;
            next_ack_drive = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_frame   <= 1'b0;
            first_byte <= 1'b0;
            addressed  <= 1'b0;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            ack_drive  <= 1'b0;
        end else begin
            in_frame   <= next_in_frame;
            first_byte <= next_first_byte;
            addressed  <= next_addressed;
            bitcnt     <= next_bitcnt;
            shreg      <= next_shreg;
            ack_drive  <= next_ack_drive;
        end
    end

    // Open-drain acknowledge: only ever pulls low
    assign link.sda_dev_o  = 1'b0;
    assign link.sda_dev_oe = ack_drive;

    // ============================================================
    // Display sequencer
    ldoec_dstate_t state;
    ldoec_dstate_t next_state;
    ldoec_fr_t     fr;
    ldoec_fr_t     next_fr;
    logic          next_ext_mode;
    logic [10:0]   frame_cnt;
    logic [10:0]   next_frame_cnt;
    logic [15:0]   osc_cnt;
    logic [15:0]   next_osc_cnt;
    logic [49:0]   next_seg;
    logic [3:0]    next_com;
    logic [10:0]   div;
    logic          tick;
    logic          boundary;
    logic          on_cmd;
    logic          off_cmd;
    logic          srst_cmd;

    // Common phase: each of the four commons owns a quarter of the frame
    function automatic logic [3:0] com_select(input logic [10:0] cnt,
                                              input logic [10:0] fdiv);
        logic [10:0] q;
        q = fdiv >> 2;
        if (cnt >= 11'(q * 3))
            com_select = 4'h8;
        else if (cnt >= 11'(q * 2))
            com_select = 4'h4;
        else if (cnt >= q)
            com_select = 4'h2;
        else
            com_select = 4'h1;
    endfunction

    always_comb begin
        div      = ldoec_frame_div(fr);
        tick     = ext_mode ? (ext_f & ~next_ext_f ? 1'b0 : next_ext_f & ~ext_f)
                            : (osc_cnt == 16'(`LDOEC_OSC_CYC - 1));
        boundary = tick && (frame_cnt >= div - 11'h1);
        on_cmd   = cmd_valid && ((cmd_byte & `LDOEC_MODE_MASK) == `LDOEC_MODE_OP)
                   && cmd_byte[`LDOEC_MODE_ON_BIT];
        off_cmd  = cmd_valid && ((cmd_byte & `LDOEC_MODE_MASK) == `LDOEC_MODE_OP)
                   && !cmd_byte[`LDOEC_MODE_ON_BIT];
        srst_cmd = cmd_valid && ((cmd_byte & `LDOEC_SETUP_MASK) == `LDOEC_SETUP_OP)
                   && cmd_byte[`LDOEC_SETUP_SRST_BIT];
        next_ext_mode  = ext_mode;
        next_fr        = fr;
        next_state     = state;
        next_osc_cnt   = (ext_mode || tick) ? 16'h0000 : osc_cnt + 16'h0001;
        next_frame_cnt = boundary ? 11'h000 : (tick ? frame_cnt + 11'h001 : frame_cnt);
        if (cmd_valid && (cmd_byte & `LDOEC_SETUP_MASK) == `LDOEC_SETUP_OP)
            next_ext_mode = cmd_byte[`LDOEC_SETUP_EXT_BIT];
        if (cmd_valid && (cmd_byte & `LDOEC_DISPLAY_CONTROL_COMMAND_MASK) == `LDOEC_DISPLAY_CONTROL_COMMAND_OP)
            next_fr = ldoec_fr_t'(cmd_byte[`LDOEC_FR_LSB +: 2]);
        case (state)
            DS_PARK: begin
                if (on_cmd)
                    next_state = DS_ON;
            end
            DS_ON: begin
                if (off_cmd)
                    next_state = DS_ALIGN;
            end
            DS_ALIGN: begin
                if (on_cmd)
                    next_state = DS_ON;
                else if (boundary)
                    next_state = DS_OFFFR;
            end
            DS_OFFFR: begin
                if (on_cmd)
                    next_state = DS_ON;
                else if (boundary)
                    next_state = DS_PARK;
            end
            default: next_state = DS_PARK;
        endcase
        // Software reset wins over everything and leaves the panel grounded
        if (srst_cmd) begin
            next_state    = DS_PARK;
            next_fr       = FR_80HZ;
            next_ext_mode = 1'b0;
        end
        // Off frame scans the commons with blank segments, then all ground
        case (next_state)
            DS_ON, DS_ALIGN: begin
                next_seg = seg_data;
                next_com = com_select(next_frame_cnt, div);
            end
            DS_OFFFR: begin
                next_seg = 50'h0;
                next_com = com_select(next_frame_cnt, div);
            end
            default: begin
                next_seg = 50'h0;
                next_com = 4'h0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state     <= DS_PARK;
            fr        <= FR_80HZ;
            ext_mode  <= 1'b0;
            frame_cnt <= 11'h000;
            osc_cnt   <= 16'h0000;
            seg       <= 50'h0;
            com       <= 4'h0;
        end else begin
            state     <= next_state;
            fr        <= next_fr;
            ext_mode  <= next_ext_mode;
            frame_cnt <= next_frame_cnt;
            osc_cnt   <= next_osc_cnt;
            seg       <= next_seg;
            com       <= next_com;
        end
    end

    // Status for the user side
    assign parked        = (state == DS_PARK);
    assign shutting_down = (state == DS_ALIGN) || (state == DS_OFFFR);

endmodule // ldoec_dev

// file: design/ldoec_host.sv
// Host end: sends display on/off command strings and feeds the external clock
`timescale 1ns/10ps
module ldoec_host
    import ldoec_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    ldoec_link_if.host      link,
    input  wire logic       req_on,
    input  wire logic       req_off,
    input  wire logic [1:0] frame_rate,
    input  wire logic       ext_mode,
    output logic            busy,
    output logic            ack_err,
    output logic            off_done
);

    // ============================================================
    // Sequencer and ext clock state
    ldoec_hstate_t state;
    ldoec_hstate_t next_state;
    logic [9:0]    qcnt;
    logic [9:0]    next_qcnt;
    logic [1:0]    q;
    logic [1:0]    next_q;
    logic [3:0]    bitn;
    logic [3:0]    next_bitn;
    logic [1:0]    bidx;
    logic [1:0]    next_bidx;
    logic [1:0]    last;
    logic [1:0]    next_last;
    logic [7:0]    bytes [0:3];
    logic [7:0]    next_bytes [0:3];
    logic          cur_off;
    logic          next_cur_off;
    logic [10:0]   div;
    logic [10:0]   next_div;
    logic          next_ack_err;
    logic          next_off_done;
    logic [2:0]    sda_s;
    logic [9:0]    ext_cnt;
    logic [9:0]    next_ext_cnt;
    logic          ext_lvl;
    logic          next_ext_lvl;
    logic          ext_park;
    logic          next_ext_park;
    logic [11:0]   tail_cnt;
    logic [11:0]   next_tail_cnt;
    logic          scl_o;
    logic          sda_low;
    logic          qt;
    logic          ext_rise;
    logic          tx_bit;

    always_comb begin
        qt            = (qcnt == 10'(`LDOEC_QTR_CYC - 1));
        next_qcnt     = qt ? 10'h000 : qcnt + 10'h001;
        next_q        = qt ? q + 2'h1 : q;
        next_state    = state;
        next_bitn     = bitn;
        next_bidx     = bidx;
        next_last     = last;
        next_cur_off  = cur_off;
        next_div      = div;
        next_ack_err  = ack_err;
        next_off_done = 1'b0;
        next_ext_park = ext_park;
        next_tail_cnt = tail_cnt;
        for (int i = 0; i < 4; i++)
            next_bytes[i] = bytes[i];
        tx_bit  = (bitn < 4'h8) ? bytes[bidx][3'(4'h7 - bitn)] : 1'b1;
        scl_o   = 1'b1;
        sda_low = 1'b0;
        // Ext clock runs in external mode except once parked after an off
        next_ext_cnt = (ext_cnt == 10'(`LDOEC_EXT_HALF_CYC - 1)) ? 10'h000 : ext_cnt + 10'h001;
        next_ext_lvl = ext_lvl;
        if (ext_mode && !ext_park && ext_cnt == 10'(`LDOEC_EXT_HALF_CYC - 1))
            next_ext_lvl = ~ext_lvl;
        ext_rise = next_ext_lvl & ~ext_lvl;
        case (state)
            HS_IDLE: begin
                next_qcnt = 10'h000;
                next_q    = 2'h0;
                if (req_on || req_off) begin
                    // Whole string goes out in one transaction
                    next_bytes[0] = `LDOEC_SLAVE_ADDR;
                    next_bytes[1] = `LDOEC_SETUP_BASE | (8'(ext_mode) << `LDOEC_SETUP_EXT_BIT);
                    next_bytes[2] = req_on ? (`LDOEC_DISPLAY_CONTROL_COMMAND_BASE | (8'(frame_rate) << `LDOEC_FR_LSB))
                                           : `LDOEC_MODE_OFF;
                    next_bytes[3] = `LDOEC_MODE_ON;
                    next_last     = req_on ? 2'h3 : 2'h2;
                    next_cur_off  = !req_on;
                    next_div      = req_on ? ldoec_frame_div(ldoec_fr_t'(frame_rate)) : div;
                    next_ack_err  = 1'b0;
                    next_bidx     = 2'h0;
                    next_state    = HS_START;
                    if (req_on)
                        next_ext_park = 1'b0;
                end
            end
            HS_START: begin
                sda_low = 1'b1;
                scl_o   = (q == 2'h0);
                if (qt && q == 2'h1) begin
                    next_q     = 2'h0;
                    next_bitn  = 4'h0;
                    next_state = HS_BIT;
                end
            end
            HS_BIT: begin
                scl_o   = (q == 2'h1) || (q == 2'h2);
                sda_low = !tx_bit;
                if (qt && q == 2'h2 && bitn == 4'h8 && sda_s[2])
                    next_ack_err = 1'b1;
                if (qt && q == 2'h3) begin
                    if (bitn != 4'h8)
                        next_bitn = bitn + 4'h1;
                    else if (ack_err || bidx == last)
                        next_state = HS_STOP;
                    else begin
                        next_bitn = 4'h0;
                        next_bidx = bidx + 2'h1;
                    end
                end
            end
            HS_STOP: begin
                scl_o   = (q != 2'h0);
                sda_low = (q != 2'h2);
                if (qt && q == 2'h2) begin
                    next_tail_cnt = 12'h000;
                    if (cur_off && ext_mode && !ack_err)
                        next_state = HS_TAIL;
                    else begin
                        next_state    = HS_IDLE;
                        next_off_done = cur_off && !ack_err;
                    end
                end
            end
            HS_TAIL: begin
                // Feed strictly more than two frames of clocks, then park
                if (ext_rise)
                    next_tail_cnt = tail_cnt + 12'h001;
                if (tail_cnt > {div, 1'b0}) begin
                    next_ext_park = 1'b1;
                    next_off_done = 1'b1;
                    next_state    = HS_IDLE;
                end
            end
            default: next_state = HS_IDLE;
        endcase
    end

    // ============================================================
    // Registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state    <= HS_IDLE;
            qcnt     <= 10'h000;
            q        <= 2'h0;
            bitn     <= 4'h0;
            bidx     <= 2'h0;
            last     <= 2'h0;
            cur_off  <= 1'b0;
            div      <= `LDOEC_DIV_80HZ;
            ack_err  <= 1'b0;
            off_done <= 1'b0;
            sda_s    <= 3'h7;
            ext_cnt  <= 10'h000;
            ext_lvl  <= 1'b0;
            ext_park <= 1'b0;
            tail_cnt <= 12'h000;
            for (int i = 0; i < 4; i++)
                bytes[i] <= 8'h00;
        end else begin
            state    <= next_state;
            qcnt     <= next_qcnt;
            q        <= next_q;
            bitn     <= next_bitn;
            bidx     <= next_bidx;
            last     <= next_last;
            cur_off  <= next_cur_off;
            div      <= next_div;
            ack_err  <= next_ack_err;
            off_done <= next_off_done;
            sda_s    <= {sda_s[1:0], link.sda};
            ext_cnt  <= next_ext_cnt;
            ext_lvl  <= next_ext_lvl;
            ext_park <= next_ext_park;
            tail_cnt <= next_tail_cnt;
            for (int i = 0; i < 4; i++)
                bytes[i] <= next_bytes[i];
        end
    end

    // Pins: clock line is push-pull, data line open drain
    assign link.scl         = scl_o;
    assign link.sda_host_o  = 1'b0;
    assign link.sda_host_oe = sda_low;
    assign link.ext_clk     = ext_lvl;
    assign busy             = (state != HS_IDLE);

endmodule // ldoec_host

// file: shared/ldoec_cfg.svh
// Constants of the display-off link: command codes, dividers and timing counts
`ifndef LDOEC_CFG_SVH
`define LDOEC_CFG_SVH

// ============================================================
// Bus address and command codes
`define LDOEC_SLAVE_ADDR     8'h7c
`define LDOEC_SETUP_OP       8'he0
`define LDOEC_SETUP_MASK     8'hf0
`define LDOEC_MODE_OP        8'hc0
`define LDOEC_MODE_MASK      8'he0
`define LDOEC_DISPLAY_CONTROL_COMMAND_OP      8'ha0
`define LDOEC_DISPLAY_CONTROL_COMMAND_MASK    8'he0
`define LDOEC_MODE_ON_BIT    3
`define LDOEC_SETUP_EXT_BIT  2
`define LDOEC_SETUP_SRST_BIT 1
`define LDOEC_FR_LSB         3
`define LDOEC_SETUP_BASE     8'he9
`define LDOEC_DISPLAY_CONTROL_COMMAND_BASE    8'ha7
`define LDOEC_MODE_ON        8'hc8
`define LDOEC_MODE_OFF       8'hc0

// ============================================================
// External clocks per frame for each frame-rate setting
`define LDOEC_DIV_80HZ       11'd512
`define LDOEC_DIV_71HZ       11'd576
`define LDOEC_DIV_64HZ       11'd648
`define LDOEC_DIV_53HZ       11'd768

// ============================================================
// Timing: times in ns, counts derived at the 4 ns system clock
// Short quarter-bit and ext clock half period keep a full off tail to some
// 10k to 15k cycles; both still leave room for the three-stage pin filters
`define LDOEC_CLK_NS         4
`define LDOEC_QTR_NS         40
`define LDOEC_QTR_CYC        ((`LDOEC_QTR_NS + `LDOEC_CLK_NS - 1) / `LDOEC_CLK_NS)
`define LDOEC_EXT_HALF_NS    20
`define LDOEC_EXT_HALF_CYC   ((`LDOEC_EXT_HALF_NS + `LDOEC_CLK_NS - 1) / `LDOEC_CLK_NS)
`define LDOEC_OSC_NS         4000
`define LDOEC_OSC_CYC        ((`LDOEC_OSC_NS + `LDOEC_CLK_NS - 1) / `LDOEC_CLK_NS)

`endif

// file: shared/ldoec_link_if.sv
// Two-wire serial link plus external display clock between host and driver
`timescale 1ns/10ps
interface ldoec_link_if;
    logic scl;
    logic sda_host_o;
    logic sda_host_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic ext_clk;
    logic sda;

    // Open-drain data line with pull-up: low while any driver pulls it low
    assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

    modport host (
        output scl,
        output sda_host_o,
        output sda_host_oe,
        output ext_clk,
        input  sda
    );

    modport dev (
        input  scl,
        input  ext_clk,
        input  sda,
        output sda_dev_o,
        output sda_dev_oe
    );
endinterface

// file: shared/ldoec_pkg.sv
// Types shared by both ends of the display-off link
`include "ldoec_cfg.svh"
package ldoec_pkg;

    // ============================================================
    // Frame-rate field codes
    typedef enum logic [1:0] {
        FR_80HZ = 2'b00,
        FR_71HZ = 2'b01,
        FR_64HZ = 2'b10,
        FR_53HZ = 2'b11
    } ldoec_fr_t;

    // Display state of the device
    typedef enum logic [1:0] {
        DS_PARK  = 2'b00,
        DS_ON    = 2'b01,
        DS_ALIGN = 2'b10,
        DS_OFFFR = 2'b11
    } ldoec_dstate_t;

    // Host sequencer state
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_START = 3'b001,
        HS_BIT   = 3'b010,
        HS_STOP  = 3'b011,
        HS_TAIL  = 3'b100
    } ldoec_hstate_t;

    // External clocks per frame for a frame-rate code
    function automatic logic [10:0] ldoec_frame_div(input ldoec_fr_t fr);
        case (fr)
            FR_80HZ: ldoec_frame_div = `LDOEC_DIV_80HZ;
            FR_71HZ: ldoec_frame_div = `LDOEC_DIV_71HZ;
            FR_64HZ: ldoec_frame_div = `LDOEC_DIV_64HZ;
            default: ldoec_frame_div = `LDOEC_DIV_53HZ;
        endcase
    endfunction

endpackage

// file: sim/ldoec_link_monitor.sv
// Checker for the display-off link between host and segment driver
`timescale 1ns/10ps
module ldoec_link_monitor (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        scl,
    input wire logic        sda,
    input wire logic        ext_clk,
    input wire logic [49:0] seg,
    input wire logic [3:0]  com,
    input wire logic        parked,
    input wire logic        shutting_down,
    input wire logic        busy,
    input wire logic        off_done
);
    logic        ext_q;
    logic        sda_q;
    logic [9:0]  still;
    logic [11:0] tail;

    // ============================================================
    // Helpers: idle time of ext_clk, ext_clk rises since STOP
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
            sda_q <= 1'b1;
            still <= 10'h000;
            tail  <= 12'h000;
        end else begin
            ext_q <= ext_clk;
            sda_q <= sda;
            still <= (ext_clk != ext_q) ? 10'h000 : still + 10'h001;
            if (scl && sda && !sda_q)
                tail <= 12'h000;
            else if (ext_clk && !ext_q)
                tail <= tail + 12'h001;
        end
    end

    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // Rules on the link and the display outputs
    park_ground_a: assert property (parked |-> seg == 50'h0 && com == 4'h0)
        else $error("outputs not grounded while parked");
    park_hold_a: assert property (parked && !busy |=> parked)
        else $error("parked dropped with no command");
    shut_park_a: assert property ($fell(shutting_down) |-> parked)
        else $error("shutdown ended without parking");
    align_wait_a: assert property ($rose(shutting_down) |-> (com != 4'h0)[*2])
        else $error("display stopped at once on off command");
    com_scan_a: assert property (shutting_down |-> $onehot(com))
        else $error("common scan lost during shutdown");
    ext_run_a: assert property (shutting_down |-> still < 10'h258)
        else $error("external clock stalled during shutdown");
    tail_len_a: assert property (off_done |-> tail > 12'h400)
        else $error("too few external clocks after off");
    done_park_a: assert property (off_done |-> parked)
        else $error("off reported done before parking");
    start_cond_a: assert property ($rose(busy) |-> ##[0:700] (scl && !sda))
        else $error("no start condition after request");

    // Main scenarios reached
    cov_park: cover property ($rose(parked));
    cov_done: cover property (off_done);
    cov_wake: cover property ($fell(parked));
endmodule // ldoec_link_monitor

// file: sim/tb_lcd_display_off_ext_clock.sv
// Testbench: display on and off at every frame rate over the link
`timescale 1ns/10ps
module tb_lcd_display_off_ext_clock
    import ldoec_pkg::*;
;
    logic        clock;
    logic        rst_n;
    logic        req_on;
    logic        req_off;
    logic [1:0]  frame_rate;
    logic        ext_mode;
    logic [49:0] seg_data;
    logic [49:0] seg;
    logic [3:0]  com;
    logic        parked;
    logic        shutting_down;
    logic        dev_ext;
    logic        busy;
    logic        ack_err;
    logic        off_done;
    int          fail_count;
    int          n_checks;

    ldoec_link_if ldoec_link_if_inst ();
    ldoec_dev ldoec_dev_inst (.clock(clock), .rst_n(rst_n), .link(ldoec_link_if_inst),
        .seg_data(seg_data), .seg(seg), .com(com), .parked(parked),
        .shutting_down(shutting_down), .ext_mode(dev_ext));
    ldoec_host ldoec_host_inst (.clock(clock), .rst_n(rst_n), .link(ldoec_link_if_inst),
        .req_on(req_on), .req_off(req_off), .frame_rate(frame_rate), .ext_mode(ext_mode),
        .busy(busy), .ack_err(ack_err), .off_done(off_done));
    ldoec_link_monitor ldoec_link_monitor_inst (.clock(clock), .rst_n(rst_n),
        .scl(ldoec_link_if_inst.scl), .sda(ldoec_link_if_inst.sda),
        .ext_clk(ldoec_link_if_inst.ext_clk), .seg(seg), .com(com), .parked(parked),
        .shutting_down(shutting_down), .busy(busy), .off_done(off_done));

    // ============================================================
    // Clock and watchdog; the whole run takes about 65k cycles
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        #400_000;
        fail_count++;
        conclude();
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Display on at a given rate, ext clock mode
    task automatic turn_on(input logic [1:0] fr);
        int i;
        @(posedge clock);
        frame_rate <= fr;
        req_on     <= 1'b1;
        @(posedge clock);
        req_on <= 1'b0;
        @(posedge clock);
        #1;
        for (i = 0; i < 5000 && busy; i++) @(posedge clock);
        #1;
        chk(parked, 1'b0);
        chk(seg, seg_data);
        chk(dev_ext, 1'b1);
    endtask

    // Display off; expects frame-aligned shutdown and a long enough clock tail
    task automatic turn_off(input logic [1:0] fr);
        int   i;
        int   rises;
        int   div;
        logic prev;
        logic seen;
        div   = (fr == 2'h0) ? 512 : (fr == 2'h1) ? 576 : (fr == 2'h2) ? 648 : 768;
        rises = 0;
        seen  = 1'b0;
        prev  = ldoec_link_if_inst.ext_clk;
        @(posedge clock);
        req_off <= 1'b1;
        @(posedge clock);
        req_off <= 1'b0;
        for (i = 0; i < 40000 && !off_done; i++) begin
            @(posedge clock);
            #1;
            // Count only clocks given after the off command was accepted
            if (seen && ldoec_link_if_inst.ext_clk && !prev) rises++;
            prev = ldoec_link_if_inst.ext_clk;
            if (shutting_down && !seen) begin
                seen = 1'b1;
                chk(parked, 1'b0);
                chk(com == 4'h0, 1'b0);
            end
        end
        chk(off_done, 1'b1);
        chk(ack_err, 1'b0);
        chk(parked, 1'b1);
        chk({seg, com}, 54'h0);
        chk(rises > 2 * div && rises < 2 * div + 100, 1'b1);
        repeat (1000) @(posedge clock);
        #1;
        chk(parked, 1'b1);
        chk({seg, com}, 54'h0);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        rst_n      = 1'b0;
        req_on     = 1'b0;
        req_off    = 1'b0;
        frame_rate = 2'h0;
        ext_mode   = 1'b1;
        seg_data   = 50'h3_5a5a_c3c3_0f0f;
        fail_count = 0;
        n_checks   = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        chk(parked, 1'b1);
        chk({seg, com}, 54'h0);
        for (int r = 0; r < 4; r++) begin
            turn_on(r[1:0]);
            turn_off(r[1:0]);
        end
        conclude();
    end
endmodule // tb_lcd_display_off_ext_clock
